/* logic/dtc_top.sv */
// Diagnostic mode, diagnostic register and delay-line register of the system controller
`timescale 1ns/1ns
module dtc_top
  import dtc_pkg::*;
#(
  parameter int unsigned LONG_RESET_CYCLES = LONG_CYCLES
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // Board pins, asynchronous
  input  wire logic                 reset_input,
  input  wire logic                 master_n,
  input  wire logic                 memr_n,
  input  wire logic                 memw_n,
  input  wire logic                 cpu_clock_input,
  input  wire logic                 cpu_type_strap,
  // Host I/O port access
  input  wire logic [15:0]          io_addr,
  input  wire logic                 io_wr,
  input  wire logic                 io_rd,
  input  wire logic [15:0]          io_wdata,
  output logic      [15:0]          io_rdata,
  // Keyboard controller side
  input  wire logic                 kbd_gate,
  input  wire logic                 kbd_d1_read,
  output logic                      d1_gate_value,
  // Refresh and speaker
  input  wire logic                 refresh_tick,
  input  wire logic                 busmaster_refresh_req,
  output logic                      busmaster_refresh_go,
  input  wire logic                 speaker_in,
  output logic                      speaker_out,
  // Delay line calibration
  input  wire logic                 delay_slow,
  output logic      [DELAY_W-1:0]   buffer_strength,
  // Gate and clock switch
  output logic                      a20_gate,
  output logic                      pmc_gate_out6,
  input  wire logic                 clock_switch_req,
  output logic                      clock_switch_reset,
  // Whole-chip output enable, low while floating
  output logic                      outputs_drive
);

  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [PIN_N-1:0] s1_q, s2_q, s3_q, pin_q;
  logic [PIN_N-1:0] pins_raw;
  assign pins_raw = {cpu_type_strap, cpu_clock_input, ~memw_n, ~memr_n, ~master_n, reset_input};

  genvar g;
  generate
    for (g = 0; g < PIN_N; g++) begin : g_sync
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          s1_q[g]  <= 1'b0;
          s2_q[g]  <= 1'b0;
          s3_q[g]  <= 1'b0;
          pin_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= pins_raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            pin_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic all_strobes;
  assign all_strobes = pin_q[PIN_MASTER] & pin_q[PIN_MEMR] & pin_q[PIN_MEMW];

  // Tri-state mode; only a reset with strobes missing leaves it
  logic float_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      float_q <= 1'b0;
    end else if (pin_q[PIN_RESET]) begin
      float_q <= all_strobes; // see RULE1 see RULE3
    end
  end // Held while reset pin is low, see RULE2

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      outputs_drive <= 1'b0;
    end else begin
      outputs_drive <= ~float_q;
    end
  end

  // Register file
  logic                 clk_test_q;
  logic                 bm_ref_q;
  logic                 auto_gate_q;
  logic                 clock_switch_long_reset_long_q;
  logic [SEL_W-1:0]     probe_select_q;
  logic                 hold_q;
  logic                 freeze_q;
  logic [DELAY_W-1:0]   delay_q;
  logic                 alt_gate_q;
  logic                 cpu_type_q;
  logic                 strap_taken_q;

  logic wr_probe_select, wr_delay, wr_sys;
  assign wr_probe_select  = io_wr && (io_addr == ADDR_PROBE_SELECT);
  assign wr_delay = io_wr && (io_addr == ADDR_DELAY);
  assign wr_sys   = io_wr && (io_addr == ADDR_SYS_CTRL);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_test_q     <= 1'b0;
      bm_ref_q       <= 1'b0;
      auto_gate_q    <= 1'b0;
      clock_switch_long_reset_long_q  <= 1'b0;
      probe_select_q <= SEL_SPKR_NORMAL;
    end else if (wr_probe_select) begin
      clk_test_q     <= io_wdata[CLK_TEST_BIT];
      bm_ref_q       <= io_wdata[BM_REF_BIT];
      auto_gate_q    <= io_wdata[AUTO_GATE_BIT];
      clock_switch_long_reset_long_q  <= io_wdata[CLOCK_SWITCH_LONG_RESET_BIT];
      probe_select_q <= io_wdata[SEL_W-1:0];
    end
  end

  // Strap caught after reset release, once the synchroniser has settled
  logic [1:0] strap_wait_q;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_wait_q  <= 2'h0;
      strap_taken_q <= 1'b0;
      cpu_type_q    <= 1'b0;
    end else if (!strap_taken_q) begin
      // Filtered copy lags one edge, so take the agreeing stages directly
      if (strap_wait_q != 2'h3) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end else if (s2_q[PIN_CPUTYP] == s3_q[PIN_CPUTYP]) begin
        strap_taken_q <= 1'b1;
        cpu_type_q    <= s3_q[PIN_CPUTYP]; // see RULE11
      end
    end
  end

  // Busmaster refresh gated by the support bit
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busmaster_refresh_go <= 1'b0;
    end else begin
      busmaster_refresh_go <= busmaster_refresh_req & bm_ref_q; // see RULE5
    end
  end

  // Gate logic
  logic eff_gate;
  assign eff_gate = alt_gate_q | kbd_gate; // see RULE6

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      alt_gate_q <= 1'b0;
    end else if (wr_sys) begin
      alt_gate_q <= io_wdata[ALT_GATE_BIT];
    end else if (auto_gate_q) begin
      alt_gate_q <= kbd_gate; // see RULE7
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      a20_gate <= 1'b0;
    end else begin
      a20_gate <= eff_gate;
    end
  end

  // Port writes show at once; keyboard changes wait for refresh
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pmc_gate_out6 <= 1'b0;
    end else if (wr_sys) begin
      pmc_gate_out6 <= io_wdata[ALT_GATE_BIT] | kbd_gate; // see RULE9
    end else if (refresh_tick) begin
      pmc_gate_out6 <= eff_gate; // see RULE9
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      d1_gate_value <= 1'b0;
    end else if (kbd_d1_read) begin
      d1_gate_value <= alt_gate_q; // see RULE8
    end
  end

  // Probe selection and speaker; reserved codes read zero
  logic probe_state;
  assign probe_state = (probe_select_q == SEL_SPKR_NORMAL) ? speaker_in : 1'b0; // see RULE12

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      speaker_out <= 1'b0;
    end else begin
      speaker_out <= speaker_in & (probe_select_q != SEL_SPKR_OFF); // see RULE13
    end
  end

  // Delay line
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      hold_q   <= 1'b0;
      freeze_q <= 1'b0;
    end else if (wr_delay) begin
      hold_q   <= io_wdata[HOLD_BIT];
      freeze_q <= io_wdata[FREEZE_BIT]; // see RULE17
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      delay_q <= DELAY_RESET;
    end else if (wr_delay && freeze_q) begin
      delay_q <= io_wdata[DELAY_W-1:0]; // see RULE18
    end else if (refresh_tick && !freeze_q) begin
      // Saturate so calibration never wraps strength end to end
      if (delay_slow && delay_q != {DELAY_W{1'b1}}) begin
        delay_q <= delay_q + DELAY_ONE; // see RULE16
      end else if (!delay_slow && delay_q != {DELAY_W{1'b0}}) begin
        delay_q <= delay_q - DELAY_ONE; // see RULE16
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      buffer_strength <= DELAY_RESET;
    end else if (!hold_q) begin
      buffer_strength <= delay_q; // see RULE14 see RULE15
    end
  end

  // Clock-switch reset pulse
  dtc_sw_state_e sw_q;
  logic [31:0]   sw_cnt_q;
  logic          cpu_clock_input_d_q;
  logic          cpu_clock_input_rise;
  assign cpu_clock_input_rise = pin_q[PIN_CPU_CLOCK_INPUT] & ~cpu_clock_input_d_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cpu_clock_input_d_q <= 1'b0;
    end else begin
      cpu_clock_input_d_q <= pin_q[PIN_CPU_CLOCK_INPUT];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sw_q     <= DTC_SW_IDLE;
      sw_cnt_q <= 32'h0;
    end else begin
      unique case (sw_q)
        DTC_SW_IDLE: begin
          if (clock_switch_req) begin
            sw_q     <= DTC_SW_TIME;
            sw_cnt_q <= clock_switch_long_reset_long_q ? 32'(LONG_RESET_CYCLES - 1) : 32'(SHORT_CYCLES - 1); // see RULE10
          end
        end
        DTC_SW_TIME: begin
          if (sw_cnt_q != 32'h0) begin
            sw_cnt_q <= sw_cnt_q - 32'h1;
          end else if (clock_switch_long_reset_long_q) begin
            sw_q <= DTC_SW_IDLE;
          end else begin
            sw_q     <= DTC_SW_CLKS;
            sw_cnt_q <= 32'(CPU_CLK_EXTRA);
          end
        end
        DTC_SW_CLKS: begin
          if (sw_cnt_q == 32'h0) begin
            sw_q <= DTC_SW_IDLE;
          end else if (cpu_clock_input_rise) begin
            sw_cnt_q <= sw_cnt_q - 32'h1; // see RULE10
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clock_switch_reset <= 1'b0;
    end else begin
      clock_switch_reset <= (sw_q != DTC_SW_IDLE) && !(sw_q == DTC_SW_CLKS && sw_cnt_q == 32'h0);
    end
  end

  // Read data, registered; unmapped ports read zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (io_addr == ADDR_PROBE_SELECT) begin
      rd_mux[REV_LSB+2:REV_LSB]  = SILICON_REVISION; // see RULE4
      rd_mux[CLK_TEST_BIT]       = clk_test_q;
      rd_mux[BM_REF_BIT]         = bm_ref_q;
      rd_mux[AUTO_GATE_BIT]      = auto_gate_q;
      rd_mux[CLOCK_SWITCH_LONG_RESET_BIT]         = clock_switch_long_reset_long_q;
      rd_mux[CPU_TYPE_BIT]       = cpu_type_q; // see RULE11
      rd_mux[PROBE_BIT]          = probe_state; // see RULE12
      rd_mux[SEL_W-1:0]          = probe_select_q;
    end else if (io_addr == ADDR_DELAY) begin
      rd_mux[HOLD_BIT]           = hold_q;
      rd_mux[FREEZE_BIT]         = freeze_q;
      rd_mux[DELAY_W-1:0]        = delay_q;
    end else if (io_addr == ADDR_SYS_CTRL) begin
      rd_mux[ALT_GATE_BIT]       = alt_gate_q;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      io_rdata <= 16'h0000;
    end else if (io_rd) begin
      io_rdata <= rd_mux;
    end
  end

endmodule : dtc_top

/* shared/dtc_pkg.sv */
// Constants, register layout and timing for the diagnostic and test control block
// What this block does
// RULE1: Reset plus all three strobes floats outputs
// RULE2: Float mode holds after reset release with strobes
// RULE3: Reset without all strobes restores output drive
// RULE4: Three-bit silicon revision in top bits
// RULE5: Busmaster refresh only when support bit set
// RULE6: Gate is alternate bit OR keyboard gate
// RULE7: Auto tracking makes alternate bit follow keyboard
// RULE8: Keyboard D1 read returns alternate gate state
// RULE9: Gate on output 6, port write immediate
// RULE10: Clock-switch reset 1 us+16 clocks or 1 ms
// RULE11: Processor type sampled at power-up, bit 7
// RULE12: Bit 6 shows selected probe signal live
// RULE13: Select 0 speaker normal, 1 speaker silenced
// RULE14: Six-bit delay count sets buffer strength
// RULE15: Strength hold bit freezes buffer strength
// RULE16: Delay line steps once per refresh cycle
// RULE17: Delay freeze bit stops calibration steps
// RULE18: Delay count writable only while frozen
// RULE19: Software keeps clock-test zero, refresh needs logic
package dtc_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned SHORT_TIME_NS   = 1000;
  localparam int unsigned LONG_TIME_US    = 1000;
  localparam int unsigned SHORT_CYCLES    = (SHORT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned LONG_CYCLES     = LONG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CPU_CLK_EXTRA   = 16;

  localparam logic [15:0] ADDR_PROBE_SELECT       = 16'h9872;
  localparam logic [15:0] ADDR_DELAY      = 16'hA072;
  localparam logic [15:0] ADDR_SYS_CTRL   = 16'h0092;

  // Diagnostic control fields
  localparam int REV_LSB       = 13;
  localparam int CLK_TEST_BIT  = 12;
  localparam int BM_REF_BIT    = 11;
  localparam int AUTO_GATE_BIT = 10;
  localparam int CLOCK_SWITCH_LONG_RESET_BIT    = 8;
  localparam int CPU_TYPE_BIT  = 7;
  localparam int PROBE_BIT     = 6;
  localparam int SEL_W         = 6;

  // Delay line control fields
  localparam int HOLD_BIT      = 7;
  localparam int FREEZE_BIT    = 6;
  localparam int DELAY_W       = 6;

  localparam int ALT_GATE_BIT  = 1;

  localparam logic [SEL_W-1:0]   SEL_SPKR_NORMAL = 6'h00;
  localparam logic [SEL_W-1:0]   SEL_SPKR_OFF    = 6'h01;
  localparam logic [DELAY_W-1:0] DELAY_RESET     = 6'h20;
  localparam logic [DELAY_W-1:0] DELAY_ONE       = 6'h01;

  // Arbitrary value, not a real part's revision
  localparam logic [2:0] SILICON_REVISION = 3'h5;

  // Synchronised pin vector positions
  localparam int PIN_RESET  = 0;
  localparam int PIN_MASTER = 1;
  localparam int PIN_MEMR   = 2;
  localparam int PIN_MEMW   = 3;
  localparam int PIN_CPU_CLOCK_INPUT = 4;
  localparam int PIN_CPUTYP = 5;
  localparam int PIN_N      = 6;

  typedef enum logic [1:0] {
    DTC_SW_IDLE  = 2'b00,
    DTC_SW_TIME  = 2'b01,
    DTC_SW_CLKS  = 2'b11
  } dtc_sw_state_e;

endpackage : dtc_pkg

/* sim/dtc_asserts.sv */
// Port-level checks for the diagnostic and test control block
`timescale 1ns/1ns
module dtc_asserts
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // Board pins
  input wire logic        reset_input,
  input wire logic        master_n,
  input wire logic        memr_n,
  input wire logic        memw_n,
  // Host port and side signals
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic [15:0] io_rdata,
  input wire logic        kbd_gate,
  input wire logic        speaker_in,
  input wire logic        speaker_out,
  input wire logic        a20_gate,
  input wire logic        clock_switch_reset,
  input wire logic        outputs_drive
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic float_pins = reset_input && !master_n && !memr_n && !memw_n;
  wire logic probe_select_rd    = io_rd && io_addr == ADDR_PROBE_SELECT;
  rev_field_a: assert property (probe_select_rd |=> io_rdata[15:13] == SILICON_REVISION)
    else $error("revision field wrong");
  gate_or_a: assert property (!$past(reset) && $past(kbd_gate) |-> a20_gate)
    else $error("gate not raised by keyboard");
  pulse_width_a:
    assert property ($rose(clock_switch_reset) |-> clock_switch_reset[*8] ##1 clock_switch_reset[*2])
    else $error("clock switch pulse too short");
  float_enter_a: assert property (float_pins [*8] |-> !outputs_drive)
    else $error("outputs not floated");
  // Eight quiet cycles cover the pin synchroniser, after which float must hold and drive may not return
  float_hold_a: assert property ((!reset_input) [*8] ##0 !outputs_drive |=> !outputs_drive)
    else $error("float left without reset pin");
  drive_back_a: assert property ((reset_input && memw_n) [*8] |-> outputs_drive)
    else $error("outputs not driven");
  probe_live_a:
    assert property (probe_select_rd ##1 io_rdata[5:0] == SEL_SPKR_NORMAL |-> io_rdata[PROBE_BIT] == $past(speaker_in))
    else $error("probe bit not live speaker");
  speaker_off_a: assert property (probe_select_rd ##1 io_rdata[5:0] == SEL_SPKR_OFF |-> !speaker_out)
    else $error("speaker not silenced");
endmodule : dtc_asserts

bind dtc_top dtc_asserts u_checks (.*);

/* sim/dtc_board_model.sv */
// Board tester and processor side model: strobes, reset pin, processor clock, type strap
`timescale 1ns/1ns
module dtc_board_model (
  // Tester requests from the bench
  input  wire logic tst_rst,
  input  wire logic tst_flt,
  // Board pins
  output logic      reset_input,
  output logic      master_n,
  output logic      memr_n,
  output logic      memw_n,
  output logic      cpu_clock_input,
  output logic      cpu_type_strap
);
  // Processor clock slowed to four sys_clk periods: the pin filter drops anything faster
  initial begin
    cpu_clock_input = 1'b0;
    forever #200 cpu_clock_input = ~cpu_clock_input;
  end
  assign reset_input = tst_rst;
  assign {master_n, memr_n, memw_n} = {3{~tst_flt}};
  // Fitted processor is the 32-bit-core type
  assign cpu_type_strap = 1'b1;
endmodule : dtc_board_model

/* sim/testbench.sv */
// Self-checking bench for the diagnostic and test control block
`timescale 1ns/1ns
module testbench
  import dtc_pkg::*;
;
  localparam int unsigned LONG_N = 20;
  // Processor clock period in sys_clk cycles, as the board model makes it
  localparam int unsigned CPU_CYC = 4;
  logic               sys_clk, reset, io_wr, io_rd, kbd_gate, kbd_d1_read, refresh_tick, tst_rst, tst_flt;
  logic               busmaster_refresh_req, speaker_in, delay_slow, clock_switch_req, busmaster_refresh_go;
  logic [15:0]        io_addr, io_wdata, io_rdata;
  logic [DELAY_W-1:0] buffer_strength;
  logic               reset_input, master_n, memr_n, memw_n, cpu_clock_input, cpu_type_strap;
  logic               d1_gate_value, speaker_out, a20_gate, pmc_gate_out6, clock_switch_reset, outputs_drive;
  int                 failures, tests_run, cycles, n;
  dtc_top #(.LONG_RESET_CYCLES(LONG_N)) dut (.*);
  dtc_board_model board (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  // Callers keep bit 12 clear; its effect is unknown
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rc(input logic [15:0] a, input logic [15:0] e);
    {io_addr, io_rd} = {a, 1'b1};
    tick(1);
    io_rd = 1'b0;
    chk(io_rdata, e);
    tick(1);
  endtask : rc
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic t_regs;
    rc(ADDR_PROBE_SELECT, 16'hA0C0);
    rc(ADDR_DELAY, 16'h0020);
    rc(16'h1234, 16'h0000);
    chk(outputs_drive, 1'b1);
    for (int s = 2; s >= 0; s--) begin
      wr(ADDR_PROBE_SELECT, 16'(s));
      rc(ADDR_PROBE_SELECT, 16'hA080 | 16'(s) | (s == 0 ? 16'h0040 : 16'h0000));
      chk(speaker_out, s != 1);
    end
    speaker_in = 1'b0;
    rc(ADDR_PROBE_SELECT, 16'hA080);
    chk(speaker_out, 1'b0);
    speaker_in = 1'b1;
    busmaster_refresh_req = 1'b1;
    tick(2);
    chk(busmaster_refresh_go, 1'b0);
    wr(ADDR_PROBE_SELECT, 16'h0800);
    chk(busmaster_refresh_go, 1'b1);
    busmaster_refresh_req = 1'b0;
    $display("test registers done");
  endtask : t_regs
  task automatic t_delay;
    repeat (3) pulse(refresh_tick);
    rc(ADDR_DELAY, 16'h0023);
    chk(buffer_strength, 6'h23);
    wr(ADDR_DELAY, 16'h0011);
    rc(ADDR_DELAY, 16'h0023);
    // Freeze takes effect only after its own write
    wr(ADDR_DELAY, 16'h0051);
    rc(ADDR_DELAY, 16'h0063);
    wr(ADDR_DELAY, 16'h0051);
    pulse(refresh_tick);
    rc(ADDR_DELAY, 16'h0051);
    wr(ADDR_DELAY, 16'h00D1);
    wr(ADDR_DELAY, 16'h00D5);
    chk(buffer_strength, 6'h11);
    wr(ADDR_DELAY, 16'h0000);
    pulse(refresh_tick);
    chk(buffer_strength, 6'h01);
    delay_slow = 1'b0;
    repeat (2) pulse(refresh_tick);
    rc(ADDR_DELAY, 16'h0000);
    $display("test delay done");
  endtask : t_delay
  task automatic t_gate;
    wr(ADDR_SYS_CTRL, 16'h0002);
    chk(a20_gate, 1'b1);
    chk(pmc_gate_out6, 1'b1);
    wr(ADDR_SYS_CTRL, 16'h0000);
    chk(a20_gate, 1'b0);
    chk(pmc_gate_out6, 1'b0);
    wr(ADDR_PROBE_SELECT, 16'h0400);
    kbd_gate = 1'b1;
    tick(1);
    chk(pmc_gate_out6, 1'b0);
    pulse(refresh_tick);
    chk(pmc_gate_out6, 1'b1);
    rc(ADDR_SYS_CTRL, 16'h0002);
    pulse(kbd_d1_read);
    chk(d1_gate_value, 1'b1);
    kbd_gate = 1'b0;
    tick(2);
    pulse(kbd_d1_read);
    chk(d1_gate_value, 1'b0);
    $display("test gate done");
  endtask : t_gate
  task automatic t_switch;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_PROBE_SELECT, m ? 16'h0100 : 16'h0000);
      pulse(clock_switch_req);
      n = 0;
      while (clock_switch_reset === 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      // Short width: 1 us, then 16 processor clocks, first one caught at any phase
      chk(m ? (n >= LONG_N - 1 && n <= LONG_N + 1) : (n >= SHORT_CYCLES + (CPU_CLK_EXTRA - 1) * CPU_CYC &&
          n <= SHORT_CYCLES + CPU_CLK_EXTRA * CPU_CYC + 1), 1'b1);
    end
    $display("test clock switch done");
  endtask : t_switch
  task automatic t_float;
    {tst_rst, tst_flt} = 2'b11;
    tick(10);
    chk(outputs_drive, 1'b0);
    tst_rst = 1'b0;
    tick(10);
    chk(outputs_drive, 1'b0);
    tst_flt = 1'b0;
    tick(10);
    chk(outputs_drive, 1'b0);
    tst_rst = 1'b1;
    tick(10);
    chk(outputs_drive, 1'b1);
    tst_rst = 1'b0;
    $display("test float done");
  endtask : t_float
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {io_wr, io_rd, kbd_gate, kbd_d1_read, refresh_tick, busmaster_refresh_req, clock_switch_req} = '0;
    {tst_rst, tst_flt, io_addr, io_wdata, failures, tests_run, cycles} = '0;
    {speaker_in, delay_slow, reset} = 3'b111;
    tick(5);
    reset = 1'b0;
    tick(5);
    t_regs();
    t_delay();
    t_gate();
    t_switch();
    t_float();
    tally_and_finish();
  end
endmodule : testbench
